/* File: verilog/tcc_pkg.sv */
// What this block does
// - A match clear from ffff to 0000 with compare ffff also sets overflow.
// - Clearing overflow before the count reaches 0001 has no effect.
// - The one-shot runs in free-run or pin a clear mode, never match mode.
// - With pin a as count clock, capture of pin a into register b is not done.
// - A capture latches at once, its interrupt at the next count clock.
// - A reverse-phase capture of pin a into register a raises no interrupt.
// - In reverse phase a pin b edge raises interrupt a and captures nothing.
// - On the first enable after reset a high pin counts as a rising edge.
// - After a stop and re-enable a high pin is not taken as a rising edge.
// - Pin a samples on every clock as count source, else on count clock.
// - An edge is seen only after the new level is sampled twice in a row.
// - While the timer is stopped both pins are ignored.
package tcc_pkg;

    // operating modes from the two mode bits
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_CLR_EDGE = 2'h2;
    localparam logic [1:0] MODE_CLR_MATCH = 2'h3;

    // count clock selection
    localparam logic [1:0] PRESC_DIV1 = 2'h0;
    localparam logic [1:0] PRESC_DIV2 = 2'h1;
    localparam logic [1:0] PRESC_DIV8 = 2'h2;
    localparam logic [1:0] PRESC_PIN = 2'h3;
    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [2:0] DIV_RESET = 3'h0;

    // valid edge selection codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_NONE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // counter values
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] CC_RESET = 16'h0000;

    // one-shot pulse sequencer
    typedef enum logic [1:0] {OS_IDLE, OS_WAIT, OS_ACTIVE} tcc_os_e;

endpackage : tcc_pkg

/* File: verilog/tcc_edge_filter.sv */
`timescale 1ns/1ps
module tcc_edge_filter (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic sample_en,
    input wire logic run,
    output logic rise,
    output logic fall
);
    logic sync1;
    logic sync2;
    logic samp;
    logic lvl;
    logic seen_run;
    logic next_samp;
    logic next_lvl;
    logic next_seen_run;
    logic next_rise;
    logic next_fall;

    // two-flop synchroniser, first stage read only by the second
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end
        else
        begin
            sync1 <= pin;
            sync2 <= sync1;
        end
    end

    // filter: while running, level moves only after two equal samples in a row
    always_comb
    begin
        next_samp = sample_en ? sync2 : samp;
        next_lvl = lvl;
        next_seen_run = seen_run | run;
        next_rise = 1'b0;
        next_fall = 1'b0;
        if (!run)
        begin
            // silent tracking once enabled, so no false edge on restart
            if (seen_run)
                next_lvl = sync2;
        end
        else if (sample_en && (sync2 == samp) && (sync2 != lvl))
        begin
            next_lvl = sync2;
            next_rise = sync2; // level held low until first run
            next_fall = !sync2;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            samp <= 1'b0;
            lvl <= 1'b0;
            seen_run <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end
        else
        begin
            samp <= next_samp;
            lvl <= next_lvl;
            seen_run <= next_seen_run;
            rise <= next_rise;
            fall <= next_fall;
        end
    end

    two_samples_a: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (rise || fall) |-> $past(sample_en) && $past(run)
            && ($past(samp) == lvl) && ($past(sync2) == lvl))
        else $error("edge reported without two equal samples");

endmodule : tcc_edge_filter

/* File: verilog/tcc_timer.sv */
`timescale 1ns/1ps
module tcc_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic trigger_pin_a,
    input wire logic trigger_pin_b,
    input wire logic op_mode_bit_high,
    input wire logic op_mode_bit_low,
    input wire logic [1:0] prescaler_select,
    input wire logic edge_select_high,
    input wire logic edge_select_low,
    input wire logic [1:0] edge_select_b,
    input wire logic capture_phase_select,
    input wire logic capture_mode_a,
    input wire logic capture_mode_b,
    input wire logic oneshot_en,
    input wire logic cc_a_wr,
    input wire logic [15:0] cc_a_wdata,
    input wire logic cc_b_wr,
    input wire logic [15:0] cc_b_wdata,
    input wire logic overflow_clr,
    output logic [15:0] count_register,
    output logic [15:0] capture_compare_a,
    output logic [15:0] capture_compare_b,
    output logic overflow_flag,
    output logic capture_irq_a,
    output logic capture_irq_b,
    output logic pulse_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic [1:0] mode;
    logic [1:0] edge_sel_a;
    logic running;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic a_samp_en;
    logic count_tick;
    logic a_valid;
    logic a_rev;
    logic b_valid;
    logic clear_edge;
    logic ovf_event;
    logic cap_a_evt;
    logic cap_b_evt;
    logic set_a;
    logic set_b;
    logic [2:0] div_cnt;
    logic [2:0] next_div_cnt;
    logic [15:0] next_count;
    logic next_ovf;
    logic ovf_hold;
    logic next_ovf_hold;
    logic [15:0] next_cc_a;
    logic [15:0] next_cc_b;
    logic pend_a;
    logic pend_b;
    logic next_pend_a;
    logic next_pend_b;
    logic next_irq_a;
    logic next_irq_b;
    tcc_pkg::tcc_os_e os_state;
    tcc_pkg::tcc_os_e next_os_state;
    logic os_allowed;
    logic next_pulse;

    // true when the selected edge kind has been seen
    function automatic logic edge_valid(input logic [1:0] sel,
                                        input logic rise,
                                        input logic fall);
        logic hit;
        hit = 1'b0;
        case (sel)
            tcc_pkg::EDGE_FALL: hit = fall;
            tcc_pkg::EDGE_RISE: hit = rise;
            tcc_pkg::EDGE_BOTH: hit = rise | fall;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_valid

    assign mode = {op_mode_bit_high, op_mode_bit_low};
    assign edge_sel_a = {edge_select_high, edge_select_low};
    assign running = (mode != tcc_pkg::MODE_STOP);

    // pin a samples on every clock when it is the count source
    assign a_samp_en = (prescaler_select == tcc_pkg::PRESC_PIN) ?
                       1'b1 : count_tick;

    tcc_edge_filter u_filt_a (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(trigger_pin_a),
        .sample_en(a_samp_en),
        .run(running),
        .rise(a_rise),
        .fall(a_fall)
    );

    // pin b serves as capture trigger, or as interrupt a source in reverse phase
    tcc_edge_filter u_filt_b (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(trigger_pin_b),
        .sample_en(count_tick),
        .run(running),
        .rise(b_rise),
        .fall(b_fall)
    );

    // edge decoding shared by counting, capture and one-shot
    assign a_valid = edge_valid(edge_sel_a, a_rise, a_fall);
    assign a_rev = edge_valid(edge_sel_a, a_fall, a_rise);
    assign b_valid = edge_valid(edge_select_b, b_rise, b_fall);

    // prescaler: count clock as a one-cycle enable
    always_comb
    begin
        next_div_cnt = running ? div_cnt + 3'h1 : tcc_pkg::DIV_RESET;
        case (prescaler_select)
            tcc_pkg::PRESC_DIV1: count_tick = running;
            tcc_pkg::PRESC_DIV2:
                count_tick = running && (div_cnt == tcc_pkg::DIV2_LAST);
            tcc_pkg::PRESC_DIV8:
                count_tick = running && (div_cnt == tcc_pkg::DIV8_LAST);
            // gated so a late pin edge cannot tick a stopped timer
            default: count_tick = running && a_valid;
        endcase
        if (prescaler_select == tcc_pkg::PRESC_DIV2 &&
            div_cnt == tcc_pkg::DIV2_LAST)
            next_div_cnt = tcc_pkg::DIV_RESET;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt <= tcc_pkg::DIV_RESET;
        else
            div_cnt <= next_div_cnt;
    end

    // counter with clear on pin a edge or on match with register a
    assign clear_edge = (mode == tcc_pkg::MODE_CLR_EDGE) && a_valid;
    // a match clear at ffff is the same event as a wrap
    assign ovf_event = count_tick && !clear_edge &&
                       (count_register == tcc_pkg::COUNT_MAX);

    always_comb
    begin
        next_count = count_register;
        if (!running)
            next_count = tcc_pkg::COUNT_ZERO;
        else if (clear_edge)
            next_count = tcc_pkg::COUNT_ZERO;
        else if (count_tick)
        begin
            if (mode == tcc_pkg::MODE_CLR_MATCH &&
                count_register == capture_compare_a)
                next_count = tcc_pkg::COUNT_ZERO;
            else
                next_count = count_register + tcc_pkg::COUNT_ONE;
        end
        // hold stays until the counter has moved off zero
        next_ovf_hold = ovf_event | (ovf_hold & ~count_tick);
        // set wins over clear; clear is void while hold stands
        next_ovf = ovf_event | ovf_hold |
                   (overflow_flag & ~overflow_clr);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_register <= tcc_pkg::COUNT_ZERO;
            overflow_flag <= 1'b0;
            ovf_hold <= 1'b0;
        end
        else
        begin
            count_register <= next_count;
            overflow_flag <= next_ovf;
            ovf_hold <= next_ovf_hold;
        end
    end

    // capture sources; pin a as count clock makes pin a capture unsafe
    assign cap_a_evt = capture_mode_a &&
        (capture_phase_select ? a_rev : b_valid);
    assign cap_b_evt = capture_mode_b && a_valid &&
        (prescaler_select != tcc_pkg::PRESC_PIN);
    // reverse-phase capture stays silent; pin b edge still interrupts
    assign set_a = (capture_phase_select ? b_valid : cap_a_evt) ||
        (!capture_mode_a && count_tick &&
         count_register == capture_compare_a);
    assign set_b = cap_b_evt || (!capture_mode_b && count_tick &&
        count_register == capture_compare_b);

    // capture latches now, interrupt waits for the next count clock
    always_comb
    begin
        next_cc_a = capture_compare_a;
        next_cc_b = capture_compare_b;
        if (cap_a_evt)
            next_cc_a = count_register;
        else if (cc_a_wr)
            next_cc_a = cc_a_wdata;
        if (cap_b_evt)
            next_cc_b = count_register;
        else if (cc_b_wr)
            next_cc_b = cc_b_wdata;
        next_irq_a = pend_a && count_tick && !set_a;
        next_irq_b = pend_b && count_tick && !set_b;
        next_pend_a = set_a || (pend_a && !count_tick);
        next_pend_b = set_b || (pend_b && !count_tick);
        if (!running)
        begin
            next_pend_a = 1'b0;
            next_pend_b = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capture_compare_a <= tcc_pkg::CC_RESET;
            capture_compare_b <= tcc_pkg::CC_RESET;
            pend_a <= 1'b0;
            pend_b <= 1'b0;
            capture_irq_a <= 1'b0;
            capture_irq_b <= 1'b0;
        end
        else
        begin
            capture_compare_a <= next_cc_a;
            capture_compare_b <= next_cc_b;
            pend_a <= next_pend_a;
            pend_b <= next_pend_b;
            capture_irq_a <= next_irq_a;
            capture_irq_b <= next_irq_b;
        end
    end

    // one-shot: active from match b to match a after a pin a edge;
    // a retrigger while active is ignored, not restarted
    assign os_allowed = oneshot_en && (mode == tcc_pkg::MODE_FREE ||
                        mode == tcc_pkg::MODE_CLR_EDGE);

    always_comb
    begin
        next_os_state = os_state;
        case (os_state)
            tcc_pkg::OS_IDLE:
                if (a_valid)
                    next_os_state = tcc_pkg::OS_WAIT;
            tcc_pkg::OS_WAIT:
                if (count_tick && count_register == capture_compare_b)
                    next_os_state = tcc_pkg::OS_ACTIVE;
            tcc_pkg::OS_ACTIVE:
                if (count_tick && count_register == capture_compare_a)
                    next_os_state = tcc_pkg::OS_IDLE;
            default: next_os_state = tcc_pkg::OS_IDLE;
        endcase
        if (!os_allowed)
            next_os_state = tcc_pkg::OS_IDLE;
        next_pulse = (next_os_state == tcc_pkg::OS_ACTIVE);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            os_state <= tcc_pkg::OS_IDLE;
            pulse_out <= 1'b0;
        end
        else
        begin
            os_state <= next_os_state;
            pulse_out <= next_pulse;
        end
    end

    // checks
    wrap_sets_ovf_a: assert property (
        count_tick && !clear_edge && count_register == tcc_pkg::COUNT_MAX
        |=> overflow_flag && count_register == tcc_pkg::COUNT_ZERO)
        else $error("wrap did not zero counter and set overflow");

    match_ovf_a: assert property (
        mode == tcc_pkg::MODE_CLR_MATCH && count_tick &&
        capture_compare_a == tcc_pkg::COUNT_MAX &&
        count_register == tcc_pkg::COUNT_MAX |=> overflow_flag)
        else $error("match clear at ffff did not set overflow");

    early_clear_a: assert property (
        overflow_flag && overflow_clr && ovf_hold |=> overflow_flag)
        else $error("overflow clear took effect before count 0001");

    oneshot_mode_a: assert property (
        mode == tcc_pkg::MODE_CLR_MATCH |=> !pulse_out)
        else $error("one-shot pulse in match clear mode");

    pin_clock_cap_a: assert property (
        prescaler_select == tcc_pkg::PRESC_PIN && !cc_b_wr
        |=> $stable(capture_compare_b))
        else $error("pin a capture while pin a is count clock");

    irq_on_tick_a: assert property (
        capture_irq_a || capture_irq_b |-> $past(count_tick))
        else $error("capture interrupt not on a count clock");

    rev_b_nocap_a: assert property (
        capture_phase_select && !cc_a_wr && !a_rev
        |=> $stable(capture_compare_a))
        else $error("pin b edge captured in reverse-phase setup");

    rev_silent_a: assert property (
        capture_phase_select && capture_mode_a && !b_valid
        |-> !set_a)
        else $error("reverse-phase capture raised interrupt a");

    stopped_quiet_a: assert property (
        !running && $past(!running) |-> !a_rise && !a_fall &&
        !b_rise && !b_fall && !capture_irq_a && !capture_irq_b)
        else $error("pin activity while stopped");

    filter_clock_a: assert property (
        prescaler_select == tcc_pkg::PRESC_PIN |-> a_samp_en)
        else $error("pin a not sampled every clock as count source");

    ovf_seen_c: cover property (ovf_event ##1 overflow_flag);
    pulse_seen_c: cover property (pulse_out ##1 !pulse_out);
    cap_b_irq_c: cover property (cap_b_evt ##[1:20] capture_irq_b);
    ext_irq_a_c: cover property (
        capture_phase_select && b_valid ##[1:20] capture_irq_a);

endmodule : tcc_timer

/* File: verif/tcc_pin_model.sv */
`timescale 1ns/1ps
// board-side drivers of both trigger pins, push-pull, no pull resistor
module tcc_pin_model (
    input wire logic mclk,
    output logic trigger_pin_a,
    output logic trigger_pin_b
);
    initial
    begin
        trigger_pin_a = 1'b0;
        trigger_pin_b = 1'b0;
    end

    // hold a static level on pin a
    task automatic set_a(input logic lvl);
        @(posedge mclk);
        trigger_pin_a <= lvl;
    endtask : set_a

    // high pulse of w clocks; returns only once the pulse is over
    task automatic pulse(input logic sel, input int w);
        @(posedge mclk);
        if (sel)
            trigger_pin_b <= 1'b1;
        else
            trigger_pin_a <= 1'b1;
        repeat (w) @(posedge mclk);
        trigger_pin_a <= 1'b0;
        trigger_pin_b <= 1'b0;
    endtask : pulse
endmodule : tcc_pin_model

/* File: verif/tb_tcc_timer.sv */
`timescale 1ns/1ps
module tb_tcc_timer;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic op_mode_bit_high = 1'b0;
    logic op_mode_bit_low = 1'b0;
    logic [1:0] prescaler_select = 2'h0;
    logic edge_select_high = 1'b0;
    logic edge_select_low = 1'b1;
    logic [1:0] edge_select_b = 2'h1;
    logic capture_phase_select = 1'b0;
    logic capture_mode_a = 1'b0;
    logic capture_mode_b = 1'b1;
    logic oneshot_en = 1'b0;
    logic cc_a_wr = 1'b0;
    logic [15:0] cc_a_wdata = 16'h0000;
    logic cc_b_wr = 1'b0;
    logic [15:0] cc_b_wdata = 16'h0000;
    logic overflow_clr = 1'b0;
    logic trigger_pin_a;
    logic trigger_pin_b;
    logic [15:0] count_register;
    logic [15:0] capture_compare_a;
    logic [15:0] capture_compare_b;
    logic overflow_flag;
    logic capture_irq_a;
    logic capture_irq_b;
    logic pulse_out;
    logic pulse_q = 1'b0;
    int miscompares = 0;
    int checks_done = 0;
    int na = 0;
    int nb = 0;
    int np = 0;
    int sa;
    int sb;
    int sp;
    int i;
    logic [15:0] c1;

    tcc_pin_model i_tcc_pin_model (.mclk, .trigger_pin_a, .trigger_pin_b);

    tcc_timer i_tcc_timer (.mclk, .rst_n, .trigger_pin_a, .trigger_pin_b,
        .op_mode_bit_high, .op_mode_bit_low, .prescaler_select,
        .edge_select_high, .edge_select_low, .edge_select_b,
        .capture_phase_select, .capture_mode_a, .capture_mode_b,
        .oneshot_en, .cc_a_wr, .cc_a_wdata, .cc_b_wr, .cc_b_wdata,
        .overflow_clr, .count_register, .capture_compare_a,
        .capture_compare_b, .overflow_flag, .capture_irq_a,
        .capture_irq_b, .pulse_out);

    always #5 mclk = ~mclk;

    // event tallies; scenarios compare deltas, so no second writer needed
    always @(posedge mclk)
    begin
        if (capture_irq_a === 1'b1)
            na <= na + 1;
        if (capture_irq_b === 1'b1)
            nb <= nb + 1;
        if (pulse_out === 1'b1 && pulse_q !== 1'b1)
            np <= np + 1;
        pulse_q <= pulse_out;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic snap;
        sa = na;
        sb = nb;
        sp = np;
    endtask : snap

    // mode change, then let the sync and filter pipeline settle
    task automatic run(input logic [1:0] m);
        @(posedge mclk);
        op_mode_bit_high <= m[1];
        op_mode_bit_low <= m[0];
        repeat (8) @(posedge mclk);
    endtask : run

    task automatic wr(input logic b, input logic [15:0] d);
        @(posedge mclk);
        cc_a_wr <= ~b;
        cc_b_wr <= b;
        cc_a_wdata <= d;
        cc_b_wdata <= d;
        @(posedge mclk);
        cc_a_wr <= 1'b0;
        cc_b_wr <= 1'b0;
    endtask : wr

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // the long overflow walk dominates, about 66k cycles
    initial
    begin
        repeat (80000) @(posedge mclk);
        miscompares++;
        finish_test();
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk(count_register | capture_compare_b, 16'h0000);
        // pin a already high at the first enable
        i_tcc_pin_model.set_a(1'b1);
        snap();
        run(tcc_pkg::MODE_FREE);
        repeat (20) @(posedge mclk);
        chk(16'(nb - sb), 16'h0001);
        #1 c1 = count_register;
        repeat (10) @(posedge mclk);
        #1 chk(count_register, c1 + 16'h000a);
        // stop and restart with the pin still high
        run(tcc_pkg::MODE_STOP);
        snap();
        run(tcc_pkg::MODE_FREE);
        repeat (20) @(posedge mclk);
        chk(16'(nb - sb), 16'h0000);
        // pins toggling while stopped
        run(tcc_pkg::MODE_STOP);
        // restart raises a count-0 compare irq a; keep it out of the tally
        snap();
        i_tcc_pin_model.set_a(1'b0);
        i_tcc_pin_model.pulse(1'b0, 6);
        i_tcc_pin_model.pulse(1'b1, 6);
        repeat (10) @(posedge mclk);
        chk(16'(na - sa + nb - sb), 16'h0000);
        chk(count_register, 16'h0000);
        // a one-clock glitch is noise, a wide pulse captures
        run(tcc_pkg::MODE_FREE);
        snap();
        i_tcc_pin_model.pulse(1'b0, 1);
        repeat (20) @(posedge mclk);
        chk(16'(nb - sb), 16'h0000);
        c1 = capture_compare_b;
        i_tcc_pin_model.pulse(1'b0, 4);
        i = 0;
        while (capture_irq_b !== 1'b1 && i < 40)
        begin
            @(posedge mclk);
            #1 i++;
        end
        chk(16'(capture_compare_b != c1), 16'h0001);
        chk(16'(i < 40), 16'h0001);
        // pin a as count clock blocks capture of pin a into register b
        run(tcc_pkg::MODE_STOP);
        prescaler_select <= tcc_pkg::PRESC_PIN;
        edge_select_high <= 1'b1; // both edges, set while stopped
        run(tcc_pkg::MODE_FREE);
        c1 = capture_compare_b;
        for (i = 0; i < 3; i++)
        begin
            i_tcc_pin_model.pulse(1'b0, 4);
            repeat (4) @(posedge mclk); // low gap one clock wider than pulse
        end
        repeat (10) @(posedge mclk);
        chk(capture_compare_b, c1);
        #1 chk(count_register, 16'h0006);
        // reverse phase capture of pin a into register a
        run(tcc_pkg::MODE_STOP);
        prescaler_select <= tcc_pkg::PRESC_DIV1;
        edge_select_high <= 1'b0; // back to rising, still stopped
        capture_phase_select <= 1'b1;
        capture_mode_a <= 1'b1;
        capture_mode_b <= 1'b0;
        run(tcc_pkg::MODE_FREE);
        snap();
        i_tcc_pin_model.pulse(1'b0, 6);
        repeat (20) @(posedge mclk);
        chk(16'(capture_compare_a != 16'h0000), 16'h0001);
        chk(16'(na - sa), 16'h0000);
        c1 = capture_compare_a;
        i_tcc_pin_model.pulse(1'b1, 6);
        repeat (20) @(posedge mclk);
        chk(16'(na - sa), 16'h0001);
        chk(capture_compare_a, c1);
        // one-shot: free run gives a pulse, match-clear mode gives none
        run(tcc_pkg::MODE_STOP);
        capture_phase_select <= 1'b0;
        capture_mode_a <= 1'b0;
        oneshot_en <= 1'b1;
        wr(1'b0, 16'h0060);
        wr(1'b1, 16'h0040);
        run(tcc_pkg::MODE_FREE);
        snap();
        i_tcc_pin_model.pulse(1'b0, 4);
        repeat (200) @(posedge mclk);
        chk(16'(np - sp), 16'h0001);
        // pin a clear-and-start mode gives a pulse as well
        run(tcc_pkg::MODE_STOP);
        run(tcc_pkg::MODE_CLR_EDGE);
        snap();
        i_tcc_pin_model.pulse(1'b0, 4);
        repeat (200) @(posedge mclk);
        chk(16'(np - sp), 16'h0001);
        run(tcc_pkg::MODE_STOP);
        run(tcc_pkg::MODE_CLR_MATCH);
        snap();
        i_tcc_pin_model.pulse(1'b0, 4);
        repeat (200) @(posedge mclk);
        chk(16'(np - sp), 16'h0000);
        // divided count clocks: 64 mclk give 32 and 8 steps
        run(tcc_pkg::MODE_STOP);
        oneshot_en <= 1'b0;
        prescaler_select <= tcc_pkg::PRESC_DIV2;
        run(tcc_pkg::MODE_FREE);
        #1 c1 = count_register;
        repeat (64) @(posedge mclk);
        #1 chk(count_register, c1 + 16'h0020);
        run(tcc_pkg::MODE_STOP);
        prescaler_select <= tcc_pkg::PRESC_DIV8;
        run(tcc_pkg::MODE_FREE);
        #1 c1 = count_register;
        repeat (64) @(posedge mclk);
        #1 chk(count_register, c1 + 16'h0008);
        // match-clear at ffff sets overflow; an early clear is void
        run(tcc_pkg::MODE_STOP);
        prescaler_select <= tcc_pkg::PRESC_DIV1;
        wr(1'b0, 16'hffff);
        run(tcc_pkg::MODE_CLR_MATCH);
        i = 0;
        while (count_register !== 16'hffff && i < 70000)
        begin
            @(posedge mclk);
            #1 i++;
        end
        @(posedge mclk);
        overflow_clr <= 1'b1;
        @(posedge mclk);
        overflow_clr <= 1'b0;
        @(posedge mclk);
        #1 chk(16'(overflow_flag), 16'h0001);
        @(posedge mclk);
        overflow_clr <= 1'b1;
        @(posedge mclk);
        overflow_clr <= 1'b0;
        @(posedge mclk);
        #1 chk(16'(overflow_flag), 16'h0000);
        finish_test();
    end
endmodule : tb_tcc_timer
